//--- verif/ddm_chk.sv
// Checker of the pin traffic between the controller and the device.
`default_nettype none
module ddm_chk
    import ddm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic cke,
    input wire logic odt,
    input wire logic rst_n,
    input wire logic [2:0] ba,
    input wire logic [MR_W-1:0] addr,
    input wire logic [DQ_W-1:0] rdata,
    input wire logic rvalid
);
    // ==========
    // Shadow mode fields and read latency, rebuilt from the pins.
    logic [MR_W-1:0] mr0, mr1, mr3;
    logic [4:0] rd_cnt;
    wire logic [3:0] pins = {cs_n, ras_n, cas_n, we_n};
    wire logic is_mrs = (pins == PINS_MRS) && cke;
    wire logic is_rd = (pins == PINS_RD) && cke;
    wire logic [4:0] cl = CL_BASE + {2'h0, mr0[6:4]};
    wire logic [4:0] al = (mr1[4:3] == 2'h1) ? cl - 5'h01 :
        (mr1[4:3] == 2'h2) ? cl - 5'h02 : 5'h00;
    wire logic [4:0] lat = al + cl - {4'h0, mr1[DLL_OFF_BIT]};
    // A mode set loads mr0, mr1 or mr3 when the bank bits pick it; a mode set to mode register 2 loads nothing here.
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !rst_n) begin
            mr0 <= MR_RESET;
            mr1 <= MR_RESET;
            mr3 <= MR_RESET;
        end else if (is_mrs) begin
            mr0 <= (ba == BA_MR0) ? addr : mr0;
            mr1 <= (ba == BA_MR1) ? addr : mr1;
            mr3 <= (ba == BA_MR3) ? addr : mr3;
        end
    end
    // A read loads the latency plus the cycle in which the registered word stands.
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !rst_n)
            rd_cnt <= 5'h00;
        else if (is_rd && rd_cnt <= 5'h01)
            rd_cnt <= lat + 5'h01;
        else if (rd_cnt != 5'h00)
            rd_cnt <= rd_cnt - 5'h01;
    end
    // ==========
    // Properties.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    a_mrs_ba2_low: assert property (is_mrs |-> !ba[2])
        else $error("mode set with bank bit 2 high");
    a_read_on_time: assert property (rd_cnt == 5'h01 |-> rvalid)
        else $error("read word missing at its latency");
    a_no_stray_data: assert property (rvalid |-> rd_cnt == 5'h01)
        else $error("read word without a pending read");
    a_pattern_word: assert property (rvalid && mr3[PAT_EN_BIT] |->
        rdata == ((mr3[1:0] == 2'h0) ? PATTERN_WORD : 8'h00))
        else $error("pattern read gave other data");
    a_pattern_cmds: assert property (mr3[PAT_EN_BIT] |-> cke && (cs_n ||
        pins == PINS_RD || pins == PINS_NOP || (is_mrs && ba == BA_MR3)))
        else $error("illegal command in pattern mode");
    a_dll_off_mrs: assert property (is_mrs && mr1[DLL_OFF_BIT] |->
        (ba != BA_MR0 || addr[6:4] == CL6_FIELD) && (ba != BA_MR2 ||
        (addr[5:3] == CWL6_FIELD && (addr & DT_MASK) == 15'h0000)))
        else $error("latency or termination wrong with DLL off");
    a_cke_held: assert property ($rose(cke) |-> cke [*8])
        else $error("clock enable dropped after exit");
    a_odt_low_sr: assert property (!cke |-> !odt)
        else $error("termination requested in self refresh");
    c_pattern_read: cover property (rvalid && mr3[PAT_EN_BIT]);
    c_dll_off_read: cover property (rvalid && mr1[DLL_OFF_BIT]);
    c_sr_exit: cover property ($rose(cke));
endmodule
`default_nettype wire

//--- verif/dram_dll_mode_pattern_read_control_tb.sv
// Bench joining controller and device at their pins, driving the user side.
`default_nettype none
module dram_dll_mode_pattern_read_control_tb
    import ddm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========
    // Stimulus, outputs and counters.
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_valid = 1'b0;
    ddm_op_type cmd_op = OP_NOP;
    logic [2:0] cmd_ba = 3'h0;
    logic [MR_W-1:0] cmd_addr = 15'h0000;
    logic odt_req = 1'b0;
    logic dram_reset = 1'b0;
    logic cmd_ready, cmd_refused, rd_valid, dll_is_off, pattern_on, dll_off, pattern_mode;
    logic term_dynamic, refused_seen, dyn_seen, self_refresh, sr_seen;
    logic [2:0] term_code, dyn_code;
    logic [DQ_W-1:0] rd_data;
    int num_errors = 0;
    int checked = 0;
    // The clock toggles every half period.
    always #20 ref_clk = ~ref_clk;
    // Notes whether the write value of termination was applied.
    always @(posedge ref_clk) begin
        if (term_dynamic === 1'b1) begin
            dyn_seen <= 1'b1;
            dyn_code <= term_code;
        end
        if (self_refresh === 1'b1)
            sr_seen <= 1'b1;
    end
    // ==========
    // The two ends meet through the pin bundle, the checker beside it.
    ddm_if ddm_if_i();
    ddm_device ddm_device_i(.ref_clk(ref_clk), .sys_rst(sys_rst), .link(ddm_if_i),
        .dll_off(dll_off), .pattern_mode(pattern_mode), .self_refresh(self_refresh),
        .term_code(term_code), .term_dynamic(term_dynamic));
    ddm_controller ddm_controller_i(.ref_clk(ref_clk), .sys_rst(sys_rst), .link(ddm_if_i),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_ba(cmd_ba), .cmd_addr(cmd_addr),
        .cmd_wdata(8'h3C), .odt_req(odt_req), .dram_reset(dram_reset),
        .cmd_ready(cmd_ready), .cmd_refused(cmd_refused), .rd_data(rd_data),
        .rd_valid(rd_valid), .dll_is_off(dll_is_off), .pattern_on(pattern_on));
    ddm_chk ddm_chk_i(.ref_clk(ref_clk), .sys_rst(sys_rst), .cs_n(ddm_if_i.cs_n),
        .ras_n(ddm_if_i.ras_n), .cas_n(ddm_if_i.cas_n), .we_n(ddm_if_i.we_n),
        .cke(ddm_if_i.cke), .odt(ddm_if_i.odt), .rst_n(ddm_if_i.rst_n), .ba(ddm_if_i.ba),
        .addr(ddm_if_i.addr), .rdata(ddm_if_i.rdata), .rvalid(ddm_if_i.rvalid));
    // ==========
    // Shared tasks.
    task automatic conclude();
        $display("checked %0d, num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // A wait that runs out of cycles counts as a mismatch and ends the run.
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 800);
        if (n >= 800) begin
            chk(16'h0000, 16'h0001);
            conclude();
        end
    endtask
    // One user request; the refusal flag is caught in the cycle after it is taken.
    task automatic issue(input ddm_op_type op, input logic [2:0] b, input logic [MR_W-1:0] a);
        wait_ready();
        cmd_op <= op;
        cmd_ba <= b;
        cmd_addr <= a;
        cmd_valid <= 1'b1;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        @(posedge ref_clk);
        refused_seen = cmd_refused;
        repeat (2) @(posedge ref_clk);
    endtask
    // The word is counted from the return of the request to the flagged word.
    task automatic read_word(input logic [DQ_W-1:0] exp, input int lat);
        int n;
        issue(OP_READ, 3'h0, 15'h0000);
        n = 0;
        while (rd_valid !== 1'b1 && n < 40) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 40) begin
            chk(16'h0000, 16'h0001);
            conclude();
        end else begin
            chk(rd_data, exp);
            chk(16'(n), 16'(lat));
        end
    endtask
    // ==========
    // Scenarios.
    task automatic s_pattern();
        issue(OP_MRS, BA_MR3, 15'h0004);
        chk(pattern_mode, 1'b1);
        read_word(PATTERN_WORD, 4);
        issue(OP_ACT, 3'h2, 15'h0000);
        chk(refused_seen, 1'b1);
        issue(OP_MRS, BA_MR3, 15'h0005);
        read_word(8'h00, 4);
        dram_reset <= 1'b1;
        repeat (3) @(posedge ref_clk);
        dram_reset <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk(pattern_mode, 1'b0);
        issue(OP_MRS, BA_MR3, 15'h0003);
        chk(pattern_on, 1'b0);
        issue(OP_WRITE, 3'h0, 15'h0000);
        read_word(8'h3C, 4);
    endtask
    task automatic s_open_bank();
        issue(OP_ACT, 3'h1, 15'h0010);
        issue(OP_MRS, BA_MR3, 15'h0004);
        chk(refused_seen, 1'b1);
        chk(pattern_mode, 1'b0);
        issue(OP_PRE, 3'h1, 15'h0400);
        issue(OP_MRS, BA_MR3, 15'h0004);
        chk(pattern_mode, 1'b1);
        issue(OP_MRS, BA_MR3, 15'h0000);
    endtask
    task automatic s_term();
        odt_req <= 1'b1;
        issue(OP_MRS, BA_MR2, 15'h0200);
        dyn_seen = 1'b0;
        issue(OP_WRITE, 3'h0, 15'h0000);
        @(posedge ref_clk);
        chk(dyn_seen, 1'b1);
        chk(dyn_code, 3'h1);
        issue(OP_MRS, BA_MR1, 15'h00C0);
        dyn_seen = 1'b0;
        issue(OP_WRITE, 3'h0, 15'h0000);
        @(posedge ref_clk);
        chk(dyn_seen, 1'b0);
        chk(term_code, 3'h2);
        issue(OP_MRS, BA_MR1, 15'h0000);
        odt_req <= 1'b0;
    endtask
    task automatic s_dll();
        sr_seen = 1'b0;
        issue(OP_DLL_OFF, 3'h0, 15'h0000);
        wait_ready();
        chk(sr_seen, 1'b1);
        chk(self_refresh, 1'b0);
        chk(dll_off, 1'b1);
        chk(dll_is_off, 1'b1);
        issue(OP_MRS, BA_MR0, 15'h0010);
        issue(OP_MRS, BA_MR3, 15'h0004);
        read_word(PATTERN_WORD, 5);
        issue(OP_MRS, BA_MR3, 15'h0000);
        sr_seen = 1'b0;
        issue(OP_DLL_ON, 3'h0, 15'h0000);
        wait_ready();
        chk(sr_seen, 1'b1);
        chk(self_refresh, 1'b0);
        chk(dll_off, 1'b0);
    endtask
    // Reset for four cycles, then the scenarios in turn.
    initial begin
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        s_pattern();
        s_open_bank();
        s_term();
        s_dll();
        conclude();
    end
endmodule
`default_nettype wire

//--- verilog/ddm_controller.sv
// Controller end: issues DRAM commands and runs the DLL on and off procedures.
//
// The register addresses and the address-and-strobe port were decided locally.
`default_nettype none
module ddm_controller
    import ddm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    ddm_if.ctl link,
    input wire logic cmd_valid,
    input wire ddm_op_type cmd_op,
    input wire logic [2:0] cmd_ba,
    input wire logic [MR_W-1:0] cmd_addr,
    input wire logic [DQ_W-1:0] cmd_wdata,
    input wire logic odt_req,
    input wire logic dram_reset,
    output logic cmd_ready,
    output logic cmd_refused,
    output logic [DQ_W-1:0] rd_data,
    output logic rd_valid,
    output logic dll_is_off,
    output logic pattern_on
);
    // ====================================================================
    // Procedure steps.
    typedef enum logic [3:0] {
        K_DT_OFF = 4'h0, K_MR1_OFF = 4'h1, K_SRE = 4'h2, K_SRX = 4'h3,
        K_MR0_CL6 = 4'h4, K_MR2_CWL6 = 4'h5, K_MR1_ON = 4'h6, K_MR0_RST = 4'h7,
        K_DONE = 4'h8
    } ddm_step_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_STEP = 2'b01, ST_WAIT = 2'b11
    } ddm_state_type;

    // Step table: {kind, wait after the step}.
    function automatic logic [13:0] step_of(input logic dir_on, input logic [2:0] idx);
        ddm_step_type k;
        logic [9:0] w;
        k = K_DONE;
        w = 10'h001;
        if (!dir_on) begin
            unique case (idx)
                3'h0: begin k = K_DT_OFF; w = T_MRD_CK; end
                3'h1: begin k = K_MR1_OFF; w = T_MOD_CK; end
                3'h2: begin k = K_SRE; w = T_SR_CK; end
                3'h3: begin k = K_SRX; w = T_XS_CK; end
                3'h4: begin k = K_MR0_CL6; w = T_MRD_CK; end
                3'h5: begin k = K_MR2_CWL6; w = T_MOD_CK; end
                default: k = K_DONE;
            endcase
        end else begin
            unique case (idx)
                3'h0: begin k = K_SRE; w = T_SR_CK; end
                3'h1: begin k = K_SRX; w = T_XS_CK; end
                3'h2: begin k = K_MR1_ON; w = T_MRD_CK; end
                3'h3: begin k = K_MR0_RST; w = T_DLLK_CK; end
                3'h4: begin k = K_MR2_CWL6; w = T_MOD_CK; end
                default: k = K_DONE;
            endcase
        end
        return {k, w};
    endfunction

    // ====================================================================
    // State.
    ddm_state_type state;
    logic dir_on;
    logic [2:0] step_idx;
    logic [9:0] wait_cnt;
    logic [MR_W-1:0] mr0, mr1, mr2, mr3;
    logic [7:0] bank_open;
    logic [3:0] pins;
    logic [2:0] ba_q;
    logic [MR_W-1:0] addr_q;
    logic [DQ_W-1:0] wdata_q;
    logic cke_q;
    logic rst_n_q;

    wire [13:0] step = step_of(dir_on, step_idx);
    wire ddm_step_type kind = ddm_step_type'(step[13:10]);
    wire [9:0] step_wait = step[9:0];

    // User command checks; pattern mode admits only reads and mode_reg_3 writes.
    wire is_proc = cmd_op == OP_DLL_OFF || cmd_op == OP_DLL_ON;
    wire to_mr3 = cmd_op == OP_MRS && cmd_ba[1:0] == BA_MR3[1:0];
    wire pat_bad = pattern_on && cmd_op != OP_READ && !to_mr3;
    wire pat_open = to_mr3 && cmd_addr[PAT_EN_BIT] && bank_open != 8'h00;
    wire take = state == ST_IDLE && cmd_valid;
    wire refuse = pat_bad || pat_open;
    wire go_simple = take && !refuse && !is_proc;
    wire go_proc = take && !refuse && is_proc;

    // Mode values as sent: MR3 reserved bits cleared, latencies pinned while DLL off.
    wire [MR_W-1:0] mr0_cl6 = (mr0 & ~CL_MASK) | {8'h00, CL6_FIELD, 4'h0};
    wire [MR_W-1:0] mr2_cwl6 = (mr2 & ~CWL_MASK) | {9'h000, CWL6_FIELD, 3'h0};
    wire [MR_W-1:0] user_mr =
        cmd_ba[1:0] == 2'h3 ? cmd_addr & MR3_USED :
        dll_is_off && cmd_ba[1:0] == 2'h0 ? (cmd_addr & ~CL_MASK) | (mr0_cl6 & CL_MASK) :
        dll_is_off && cmd_ba[1:0] == 2'h2 ?
            (cmd_addr & ~CWL_MASK & ~DT_MASK) | (mr2_cwl6 & CWL_MASK) :
        cmd_addr;

    // Procedure step pins and address.
    wire step_mrs = kind != K_SRE && kind != K_SRX && kind != K_DONE;
    wire [1:0] step_ba =
        kind == K_DT_OFF || kind == K_MR2_CWL6 ? 2'h2 :
        kind == K_MR1_OFF || kind == K_MR1_ON ? 2'h1 : 2'h0;
    wire [MR_W-1:0] step_mr =
        kind == K_DT_OFF ? mr2 & ~DT_MASK :
        kind == K_MR1_OFF ? mr1 | 15'h0001 :
        kind == K_MR1_ON ? mr1 & ~15'h0001 :
        kind == K_MR0_RST ? mr0_cl6 | 15'h0100 :
        kind == K_MR0_CL6 ? mr0_cl6 : mr2_cwl6;

    // Mode register shadow update for whatever MRS goes out this cycle.
    wire step_fire = state == ST_STEP && step_mrs;
    wire user_mrs = go_simple && cmd_op == OP_MRS;
    wire mrs_fire = step_fire || user_mrs;
    wire [1:0] mrs_ba = step_fire ? step_ba : cmd_ba[1:0];
    wire [MR_W-1:0] mrs_val = step_fire ? step_mr : user_mr;

    wire [3:0] user_pins =
        cmd_op == OP_MRS ? PINS_MRS : cmd_op == OP_READ ? PINS_RD :
        cmd_op == OP_WRITE ? PINS_WR : cmd_op == OP_ACT ? PINS_ACT :
        cmd_op == OP_PRE ? PINS_PRE : PINS_NOP;
    wire [3:0] next_pins =
        go_simple ? user_pins :
        state == ST_STEP && kind == K_SRE ? PINS_REF :
        step_fire ? PINS_MRS : PINS_NOP;
    wire next_cke = state == ST_STEP && kind == K_SRE ? 1'b0 :
        state == ST_STEP && kind == K_SRX ? 1'b1 : cke_q;

    assign cmd_ready = state == ST_IDLE;
    assign dll_is_off = mr1[DLL_OFF_BIT];
    assign pattern_on = mr3[PAT_EN_BIT];

    // ====================================================================
    // Procedure sequencer.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            dir_on <= 1'b0;
            step_idx <= 3'h0;
            wait_cnt <= 10'h000;
        end else begin
            unique case (state)
                ST_IDLE: if (go_proc) begin
                    state <= ST_STEP;
                    dir_on <= cmd_op == OP_DLL_ON;
                    step_idx <= 3'h0;
                end
                ST_STEP: if (kind == K_DONE) begin
                    state <= ST_IDLE;
                end else begin
                    state <= ST_WAIT;
                    wait_cnt <= step_wait - 10'h001;
                end
                ST_WAIT: if (wait_cnt == 10'h000) begin
                    state <= ST_STEP;
                    step_idx <= step_idx + 3'h1;
                end else begin
                    wait_cnt <= wait_cnt - 10'h001;
                end
            endcase
        end
    end

    // Shadow mode registers and open-bank tracking.
    always_ff @(posedge ref_clk) begin
        if (sys_rst || dram_reset) begin
            mr0 <= MR_RESET;
            mr1 <= MR_RESET;
            mr2 <= MR_RESET;
            mr3 <= MR_RESET;
            bank_open <= 8'h00;
        end else begin
            if (mrs_fire) begin
                unique case (mrs_ba)
                    2'h0: mr0 <= mrs_val;
                    2'h1: mr1 <= mrs_val;
                    2'h2: mr2 <= mrs_val;
                    2'h3: mr3 <= mrs_val;
                endcase
            end
            if (go_simple && cmd_op == OP_ACT)
                bank_open[cmd_ba] <= 1'b1;
            else if (go_simple && cmd_op == OP_PRE)
                bank_open <= cmd_addr[10] ? 8'h00 : bank_open & ~(8'h01 << cmd_ba);
        end
    end

    // Pin registers; termination is held low during either procedure.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pins <= PINS_NOP;
            ba_q <= 3'h0;
            addr_q <= '0;
            wdata_q <= '0;
            cke_q <= 1'b1;
            rst_n_q <= 1'b0;
            cmd_refused <= 1'b0;
        end else begin
            pins <= next_pins;
            ba_q <= step_fire ? {1'b0, step_ba} : {1'b0, cmd_ba[1:0]};
            addr_q <= mrs_fire ? mrs_val : cmd_addr;
            wdata_q <= cmd_wdata;
            cke_q <= next_cke;
            rst_n_q <= !dram_reset;
            cmd_refused <= take && refuse;
        end
    end

    // Read data arrive flagged, so DLL-off early data need no extra alignment.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rd_data <= '0;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= link.rvalid;
            if (link.rvalid)
                rd_data <= link.rdata;
        end
    end

    assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = pins;
    assign link.ba = ba_q;
    assign link.addr = addr_q;
    assign link.wdata = wdata_q;
    assign link.cke = cke_q;
    assign link.odt = odt_req && state == ST_IDLE;
    assign link.rst_n = rst_n_q;
endmodule
`default_nettype wire

//--- verilog/ddm_device.sv
// DRAM device end: mode registers, pattern reads, DLL-off latency and termination.
`default_nettype none
module ddm_device
    import ddm_pkg::*;
#(
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    ddm_if.dev link,
    output logic dll_off,
    output logic pattern_mode,
    output logic self_refresh,
    output logic [2:0] term_code,
    output logic term_dynamic
);
    // ====================================================================
    // Command decode.
    logic [MR_W-1:0] mr0, mr1, mr2, mr3;
    logic [DQ_W-1:0] mem [DEPTH];
    logic [DQ_W-1:0] rdata;
    logic rvalid;
    logic [4:0] rd_cnt;
    logic rd_busy;
    logic [$clog2(DEPTH)-1:0] rd_col;
    logic wr_window;
    logic cke_q;

    // A deselected or no-operation cycle decodes to no command, except self-refresh exit when clock enable rises.
    wire [3:0] pins = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
    wire live = link.cke && cke_q && !self_refresh && !link.cs_n;
    wire is_mrs = live && pins == PINS_MRS;
    wire is_rd = live && pins == PINS_RD;
    wire is_wr = live && pins == PINS_WR && !pattern_mode;
    wire is_sre = link.cke == 1'b0 && cke_q && !link.cs_n && pins == PINS_REF;
    wire is_srx = link.cke && !cke_q && self_refresh;
    wire dev_rst = sys_rst || !link.rst_n;

    // Read latency: AL from MR1, CL from MR0, one less with the DLL off.
    wire [4:0] cl = CL_BASE + {2'h0, mr0[CL_LSB +: 3]};
    wire [1:0] al_sel = mr1[AL_LSB +: 2];
    wire [4:0] al = al_sel == 2'h1 ? cl - 5'h01 : al_sel == 2'h2 ? cl - 5'h02 : 5'h00;
    wire [4:0] rd_lat = al + cl - {4'h0, dll_off};
    wire [1:0] pat_loc = mr3[1:0];
    wire [DQ_W-1:0] pat_word = pat_loc == 2'h0 ? PATTERN_WORD : 8'h00;

    assign dll_off = mr1[DLL_OFF_BIT];
    assign pattern_mode = mr3[PAT_EN_BIT];

    // ====================================================================
    // Mode registers, selected by bank address and loaded from the address pins.
    always_ff @(posedge ref_clk) begin
        if (dev_rst) begin
            mr0 <= MR_RESET;
            mr1 <= MR_RESET;
            mr2 <= MR_RESET;
            mr3 <= MR_RESET;
        end else if (is_mrs && link.ba[2] == 1'b0) begin
            unique case (link.ba[1:0])
                2'h0: mr0 <= link.addr;
                2'h1: mr1 <= link.addr;
                2'h2: mr2 <= link.addr;
                2'h3: mr3 <= link.addr;
            endcase
        end
    end

    // Self refresh is entered with clock enable falling and left when it rises.
    always_ff @(posedge ref_clk) begin
        if (dev_rst) begin
            cke_q <= 1'b1;
            self_refresh <= 1'b0;
        end else begin
            cke_q <= link.cke;
            if (is_sre)
                self_refresh <= 1'b1;
            else if (is_srx)
                self_refresh <= 1'b0;
        end
    end

    // Writes outside pattern mode land in the small array; the pattern register never takes them.
    always_ff @(posedge ref_clk) begin
        if (is_wr)
            mem[link.addr[$clog2(DEPTH)-1:0]] <= link.wdata;
    end

    // One read in flight: count down the latency, then present a word.
    always_ff @(posedge ref_clk) begin
        if (dev_rst) begin
            rd_busy <= 1'b0;
            rd_cnt <= 5'h00;
            rd_col <= '0;
            rvalid <= 1'b0;
            rdata <= '0;
        end else begin
            rvalid <= 1'b0;
            if (is_rd && !rd_busy) begin
                rd_busy <= 1'b1;
                rd_cnt <= rd_lat - 5'h01;
                rd_col <= link.addr[$clog2(DEPTH)-1:0];
            end else if (rd_busy && rd_cnt != 5'h00) begin
                rd_cnt <= rd_cnt - 5'h01;
            end else if (rd_busy) begin
                rd_busy <= 1'b0;
                rvalid <= 1'b1;
                rdata <= pattern_mode ? pat_word : mem[rd_col];
            end
        end
    end

    // ====================================================================
    // Termination: the write value replaces nominal only outside write leveling.
    wire [2:0] nom = {mr1[NOM_B2], mr1[NOM_B1], mr1[NOM_B0]};
    wire [1:0] rtt_wr = mr2[DT_LSB +: 2];
    wire wlev = mr1[WLEV_BIT];
    wire use_wr = wr_window && rtt_wr != 2'h0 && !wlev;

    always_ff @(posedge ref_clk) begin
        if (dev_rst) begin
            wr_window <= 1'b0;
            term_code <= 3'h0;
            term_dynamic <= 1'b0;
        end else begin
            wr_window <= is_wr;
            term_dynamic <= link.odt && use_wr;
            term_code <= !link.odt ? 3'h0 : use_wr ? {1'b0, rtt_wr} : nom;
        end
    end

    assign link.rdata = rdata;
    assign link.rvalid = rvalid;
endmodule
`default_nettype wire

//--- verilog/ddm_if.sv
// Command, control and data pins between the controller and the DRAM device.
`default_nettype none
interface ddm_if;
    import ddm_pkg::*;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic odt;
    logic rst_n;
    logic [2:0] ba;
    logic [MR_W-1:0] addr;
    logic [DQ_W-1:0] wdata;
    logic [DQ_W-1:0] rdata;
    logic rvalid;
    modport dev (input cs_n, ras_n, cas_n, we_n, cke, odt, rst_n, ba, addr, wdata,
                 output rdata, rvalid);
    modport ctl (output cs_n, ras_n, cas_n, we_n, cke, odt, rst_n, ba, addr, wdata,
                 input rdata, rvalid);
endinterface
`default_nettype wire

//--- verilog/ddm_pkg.sv
// Shared constants, command encodings and types for both ends of the DRAM mode link.
`default_nettype none
package ddm_pkg;
    // ====================================================================
    // Link widths.
    localparam int MR_W = 15;
    localparam int DQ_W = 8;
    // ====================================================================
    // Mode register selection by bank address.
    localparam logic [2:0] BA_MR0 = 3'h0;
    localparam logic [2:0] BA_MR1 = 3'h1;
    localparam logic [2:0] BA_MR2 = 3'h2;
    localparam logic [2:0] BA_MR3 = 3'h3;
    localparam logic [MR_W-1:0] MR_RESET = 15'h0000;
    // ====================================================================
    // Field positions.
    localparam int CL_LSB = 4;
    localparam int DLL_RST_BIT = 8;
    localparam int DLL_OFF_BIT = 0;
    localparam int AL_LSB = 3;
    localparam int WLEV_BIT = 7;
    localparam int NOM_B0 = 2;
    localparam int NOM_B1 = 6;
    localparam int NOM_B2 = 9;
    localparam int CWL_LSB = 3;
    localparam int DT_LSB = 9;
    localparam int PAT_EN_BIT = 2;
    localparam logic [MR_W-1:0] MR3_USED = 15'h0007;
    localparam logic [MR_W-1:0] DT_MASK = 15'h0600;
    localparam logic [MR_W-1:0] CL_MASK = 15'h0070;
    localparam logic [MR_W-1:0] CWL_MASK = 15'h0038;
    // ====================================================================
    // Latency encodings.
    localparam logic [4:0] CL_BASE = 5'h04;
    localparam logic [2:0] CL6_FIELD = 3'h2;
    localparam logic [2:0] CWL6_FIELD = 3'h1;
    localparam logic [DQ_W-1:0] PATTERN_WORD = 8'h55;
    // ====================================================================
    // Pin codes {cs_n, ras_n, cas_n, we_n}.
    localparam logic [3:0] PINS_MRS = 4'h0;
    localparam logic [3:0] PINS_REF = 4'h1;
    localparam logic [3:0] PINS_PRE = 4'h2;
    localparam logic [3:0] PINS_ACT = 4'h3;
    localparam logic [3:0] PINS_WR = 4'h4;
    localparam logic [3:0] PINS_RD = 4'h5;
    localparam logic [3:0] PINS_NOP = 4'h7;
    localparam logic [3:0] PINS_DES = 4'hF;
    // ====================================================================
    // Timing, in clock cycles or in ns with derived cycle counts.
    localparam int CLK_NS = 40;
    localparam int T_XS_NS = 170;
    localparam logic [9:0] T_XS_CK = 10'((T_XS_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [9:0] T_MOD_CK = 10'h00C;
    localparam logic [9:0] T_MRD_CK = 10'h004;
    localparam logic [9:0] T_SR_CK = 10'h00A;
    localparam logic [9:0] T_DLLK_CK = 10'h200;
    // ====================================================================
    // User operations of the controller.
    typedef enum logic [2:0] {
        OP_NOP = 3'h0, OP_MRS = 3'h1, OP_READ = 3'h2, OP_WRITE = 3'h3,
        OP_ACT = 3'h4, OP_PRE = 3'h5, OP_DLL_OFF = 3'h6, OP_DLL_ON = 3'h7
    } ddm_op_type;
endpackage
`default_nettype wire
